// ---- froe_apb_slave.sv ----
`timescale 1ns/1ns
module froe_apb_slave
    import froe_pkg::*;
(
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        rst_n,
    // APB
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // Register side
    input  wire logic [7:0]  rd_ramctl,
    input  wire logic [7:0]  rd_fmode,
    output logic             wr_ramctl,
    output logic             wr_fmode,
    output logic      [7:0]  wr_data
);
    logic access;
    logic hit;

    assign access = psel && penable;
    assign hit    = (paddr == ADDR_RAMCTL) || (paddr == ADDR_FMODE);

    // ------------------------------------------------------------------
    // Zero wait states; unmapped reads return zero with an error.
    // ------------------------------------------------------------------
    assign pready    = 1'b1;
    assign pslverr   = access && !hit;
    assign wr_ramctl = access && pwrite && (paddr == ADDR_RAMCTL);
    assign wr_fmode  = access && pwrite && (paddr == ADDR_FMODE);
    assign wr_data   = pwdata[7:0];

    always_comb
    begin
        prdata = 32'h0000_0000;
        if (paddr == ADDR_RAMCTL)
        begin
            prdata[7:0] = rd_ramctl;
        end
        else if (paddr == ADDR_FMODE)
        begin
            prdata[7:0] = rd_fmode;
        end
    end

    logic unused_rst;
    assign unused_rst = clk ^ rst_n;

endmodule : froe_apb_slave

// ---- froe_cpu_model.sv ----
`timescale 1ns/1ns
module froe_cpu_model
(
    // Clock
    input  wire logic              clk,
    // Toward the flash controller
    output froe_pkg::froe_rd_t     flash_rd,
    output froe_pkg::froe_cpu_ev_t cpu_ev
);
    import froe_pkg::*;

    // ------------------------------------------------------------------
    // Reads and events
    // ------------------------------------------------------------------
    initial
    begin
        flash_rd = '0;
        cpu_ev   = '0;
    end

    // A released address bus shows the inverted address, so late sampling never matches.
    task automatic read_flash(input logic [15:0] addr, input logic fetch);
        flash_rd <= '{valid: 1'b1, addr: addr, fetch: fetch};
        @(posedge clk);
        flash_rd <= '{valid: 1'b0, addr: ~addr, fetch: 1'b0};
    endtask : read_flash

    // Excluded exception kinds are filtered upstream and never reach this pin.
    task automatic pulse_event(input logic exc, input logic slp);
        cpu_ev <= '{hw_exception: exc, sleep_exec: slp};
        @(posedge clk);
        cpu_ev <= '0;
    endtask : pulse_event

endmodule : froe_cpu_model

// ---- froe_flash_ctrl.sv ----
// Our own choices: the APB interface to the registers and the placing of the registers.
`timescale 1ns/1ns
// Functional notes
// - RAM enable off blocks RAM, ignores overlay
// - Bit six reserved test bit, undefined
// - Bit five reads one, writes ignored
// - Error flag forces write/erase protection
// - Error flag cleared by reset, hardware standby
// - Flash read during program/erase sets error
// - Flash read data then undefined
// - Qualifying hardware exception during program/erase sets error
// - Sleep during program/erase sets error
// - Overlay select protects all blocks
// - Emulation protection allows verify modes only
// - Overlay select writable only in on-board mode
// - Select cleared reset, hw standby, no 12V
// - Window bits same writability and clearing
// - Select writes need programming-voltage flag
// - Window codes map flash windows onto RAM
// - Voltage flag mirrors 12V presence
// - Mode bits request program, erase modes
module froe_flash_ctrl
    import froe_pkg::*;
(
    // Clock and reset
    input  wire logic                CLOCK,
    input  wire logic                RST_N,
    // APB
    input  wire logic                PSEL,
    input  wire logic                PENABLE,
    input  wire logic                PWRITE,
    input  wire logic [7:0]          PADDR,
    input  wire logic [31:0]         PWDATA,
    output logic      [31:0]         PRDATA,
    output logic                     PREADY,
    output logic                     PSLVERR,
    // Chip state
    input  wire logic                VPP_12V_PRESENT,
    input  wire logic                ONBOARD_MODE,
    input  wire logic                HW_STANDBY,
    // CPU events
    input  froe_pkg::froe_rd_t       FLASH_RD,
    input  froe_pkg::froe_cpu_ev_t   CPU_EV,
    // Flash array side
    output logic                     PROG_ACTIVE,
    output logic                     ERASE_ACTIVE,
    output logic                     PV_ACTIVE,
    output logic                     EV_ACTIVE,
    output logic                     RAM_ACCESS_ENABLE,
    output logic                     OVERLAY_HIT,
    output logic      [15:0]         OVERLAY_RAM_ADDR,
    output logic                     RD_DATA_UNDEFINED
);
    import froe_pkg::*;

    // ------------------------------------------------------------------
    // Register state
    // ------------------------------------------------------------------
    logic        ram_access_enable_ff;
    logic        test_bit_ff;
    logic        flash_error_flag_ff;
    logic        overlay_select_ff;
    logic [2:0]  overlay_window_ff;
    logic [3:0]  mode_req_ff;
    logic        pe_busy;
    logic        err_event;
    logic        nxt_flash_error_flag;
    logic        wr_ramctl;
    logic        wr_fmode;
    logic [7:0]  wr_data;
    logic [7:0]  rd_ramctl;
    logic [7:0]  rd_fmode;
    logic        overlay_on;
    logic        map_hit;
    logic [15:0] map_addr;
    logic        ovl_writable;
    logic        ovl_clear;
    logic        hit_ff;
    logic [15:0] ram_addr_ff;
    logic        undef_ff;
    logic [3:0]  active_ff;
    logic [3:0]  nxt_active;

    froe_apb_slave u_apb
    (
        .clk       (CLOCK),
        .rst_n     (RST_N),
        .psel      (PSEL),
        .penable   (PENABLE),
        .pwrite    (PWRITE),
        .paddr     (PADDR),
        .pwdata    (PWDATA),
        .prdata    (PRDATA),
        .pready    (PREADY),
        .pslverr   (PSLVERR),
        .rd_ramctl (rd_ramctl),
        .rd_fmode  (rd_fmode),
        .wr_ramctl (wr_ramctl),
        .wr_fmode  (wr_fmode),
        .wr_data   (wr_data)
    );

    // ------------------------------------------------------------------
    // RAM enable and test bit
    // ------------------------------------------------------------------
    always_ff @(posedge CLOCK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            ram_access_enable_ff <= RAMCTL_RST[BIT_RAM_EN];
            test_bit_ff          <= RAMCTL_RST[BIT_TEST];
        end
        else if (wr_ramctl)
        begin
            ram_access_enable_ff <= wr_data[BIT_RAM_EN];
            test_bit_ff          <= wr_data[BIT_TEST];
        end
    end

    // ------------------------------------------------------------------
    // Flash error flag
    // ------------------------------------------------------------------
    assign pe_busy   = active_ff[BIT_PROG] || active_ff[BIT_ERASE];
    // The exception input is already qualified by the CPU: reset, trace,
    // invalid instruction, trap and zero-divide never assert it.
    assign err_event = (pe_busy && FLASH_RD.valid && !map_hit)
                    || (CPU_EV.hw_exception && (nxt_active[BIT_PROG] || nxt_active[BIT_ERASE]))
                    || (pe_busy && CPU_EV.sleep_exec);

    always_comb
    begin
        nxt_flash_error_flag = flash_error_flag_ff || err_event;
        if (HW_STANDBY)
        begin
            nxt_flash_error_flag = 1'b0;
        end
    end

    always_ff @(posedge CLOCK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            flash_error_flag_ff <= 1'b0;
        end
        else
        begin
            flash_error_flag_ff <= nxt_flash_error_flag;
        end
    end

    // ------------------------------------------------------------------
    // Overlay select and window
    // ------------------------------------------------------------------
    assign ovl_writable = ONBOARD_MODE && VPP_12V_PRESENT;
    assign ovl_clear    = HW_STANDBY || !VPP_12V_PRESENT || !ONBOARD_MODE;

    always_ff @(posedge CLOCK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            overlay_select_ff <= 1'b0;
            overlay_window_ff <= 3'h0;
        end
        else if (ovl_clear)
        begin
            overlay_select_ff <= 1'b0;
            overlay_window_ff <= 3'h0;
        end
        else if (wr_ramctl && ovl_writable)
        begin
            overlay_select_ff <= wr_data[BIT_OVL_SEL];
            overlay_window_ff <= wr_data[BIT_WIN_HI:0];
        end
    end

    // ------------------------------------------------------------------
    // Mode control and protection
    // ------------------------------------------------------------------
    always_ff @(posedge CLOCK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            mode_req_ff <= FMODE_RST[3:0];
        end
        else if (HW_STANDBY || !VPP_12V_PRESENT)
        begin
            mode_req_ff <= FMODE_RST[3:0];
        end
        else if (wr_fmode)
        begin
            mode_req_ff <= wr_data[3:0];
        end
    end

    // Program and erase are gated off by error or emulation protection;
    // verify modes still pass so software can check the array.
    always_comb
    begin
        nxt_active            = mode_req_ff;
        nxt_active[BIT_PROG]  = mode_req_ff[BIT_PROG] && !flash_error_flag_ff
                             && !overlay_select_ff;
        nxt_active[BIT_ERASE] = mode_req_ff[BIT_ERASE] && !flash_error_flag_ff
                             && !overlay_select_ff;
    end

    always_ff @(posedge CLOCK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            active_ff <= 4'h0;
        end
        else
        begin
            active_ff <= nxt_active;
        end
    end

    // ------------------------------------------------------------------
    // Overlay mapping
    // ------------------------------------------------------------------
    assign overlay_on = ram_access_enable_ff && overlay_select_ff;

    froe_overlay_map u_map
    (
        .map_on   (overlay_on),
        .window   (overlay_window_ff),
        .cpu_addr (FLASH_RD.addr),
        .hit      (map_hit),
        .ram_addr (map_addr)
    );

    always_ff @(posedge CLOCK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            hit_ff      <= 1'b0;
            ram_addr_ff <= 16'h0000;
            undef_ff    <= 1'b0;
        end
        else
        begin
            hit_ff      <= FLASH_RD.valid && map_hit;
            ram_addr_ff <= map_addr;
            undef_ff    <= FLASH_RD.valid && !map_hit && pe_busy;
        end
    end

    // ------------------------------------------------------------------
    // Read-back
    // ------------------------------------------------------------------
    assign rd_ramctl = {ram_access_enable_ff, test_bit_ff, 1'b1,
                        flash_error_flag_ff, overlay_select_ff, overlay_window_ff};
    assign rd_fmode  = {VPP_12V_PRESENT, 3'h0, mode_req_ff};

    assign PROG_ACTIVE       = active_ff[BIT_PROG];
    assign ERASE_ACTIVE      = active_ff[BIT_ERASE];
    assign PV_ACTIVE         = active_ff[BIT_PV];
    assign EV_ACTIVE         = active_ff[BIT_EV];
    assign RAM_ACCESS_ENABLE = ram_access_enable_ff;
    assign OVERLAY_HIT       = hit_ff;
    assign OVERLAY_RAM_ADDR  = ram_addr_ff;
    assign RD_DATA_UNDEFINED = undef_ff;

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    property p_err_hold;
        @(posedge CLOCK) disable iff (!RST_N)
        flash_error_flag_ff && !HW_STANDBY |=> flash_error_flag_ff;
    endproperty
    a_err_hold: assert property (p_err_hold) else $error("error flag dropped");

    property p_err_block;
        @(posedge CLOCK) disable iff (!RST_N)
        flash_error_flag_ff |=> !PROG_ACTIVE && !ERASE_ACTIVE;
    endproperty
    a_err_block: assert property (p_err_block) else $error("pe under error");

    property p_sel_block;
        @(posedge CLOCK) disable iff (!RST_N)
        overlay_select_ff |=> !PROG_ACTIVE && !ERASE_ACTIVE;
    endproperty
    a_sel_block: assert property (p_sel_block) else $error("pe under emulation");

    property p_read_err;
        @(posedge CLOCK) disable iff (!RST_N)
        pe_busy && FLASH_RD.valid && !map_hit && !HW_STANDBY |=> flash_error_flag_ff;
    endproperty
    a_read_err: assert property (p_read_err) else $error("read did not flag");

    property p_sleep_err;
        @(posedge CLOCK) disable iff (!RST_N)
        pe_busy && CPU_EV.sleep_exec && !HW_STANDBY |=> flash_error_flag_ff;
    endproperty
    a_sleep_err: assert property (p_sleep_err) else $error("sleep did not flag");

    property p_stby_clr;
        @(posedge CLOCK) disable iff (!RST_N)
        HW_STANDBY |=> !flash_error_flag_ff && !overlay_select_ff && overlay_window_ff == 3'h0;
    endproperty
    a_stby_clr: assert property (p_stby_clr) else $error("standby clear");

    property p_novpp;
        @(posedge CLOCK) disable iff (!RST_N)
        !VPP_12V_PRESENT |=> !overlay_select_ff && overlay_window_ff == 3'h0;
    endproperty
    a_novpp: assert property (p_novpp) else $error("no 12V clear");

    property p_offmode;
        @(posedge CLOCK) disable iff (!RST_N)
        !ONBOARD_MODE |=> rd_ramctl[BIT_OVL_SEL:0] == 4'h0;
    endproperty
    a_offmode: assert property (p_offmode) else $error("overlay bits outside mode");

    property p_bit5;
        @(posedge CLOCK) disable iff (!RST_N)
        PSEL && PENABLE && !PWRITE && PADDR == ADDR_RAMCTL |-> PRDATA[BIT_ONE];
    endproperty
    a_bit5: assert property (p_bit5) else $error("bit5 not one");

    property p_ram_access_enable_off;
        @(posedge CLOCK) disable iff (!RST_N)
        !ram_access_enable_ff |=> !OVERLAY_HIT;
    endproperty
    a_ram_access_enable_off: assert property (p_ram_access_enable_off) else $error("overlay with RAM off");

    c_err_set:  cover property (@(posedge CLOCK) disable iff (!RST_N) $rose(flash_error_flag_ff));
    c_map_hit:  cover property (@(posedge CLOCK) disable iff (!RST_N) OVERLAY_HIT);
    c_prog:     cover property (@(posedge CLOCK) disable iff (!RST_N) PROG_ACTIVE);
    c_verify:   cover property (@(posedge CLOCK) disable iff (!RST_N) overlay_select_ff && PV_ACTIVE);

endmodule : froe_flash_ctrl

// ---- froe_overlay_map.sv ----
`timescale 1ns/1ns
module froe_overlay_map
    import froe_pkg::*;
(
    // Overlay setting
    input  wire logic        map_on,
    input  wire logic [2:0]  window,
    // Address in and out
    input  wire logic [15:0] cpu_addr,
    output logic             hit,
    output logic      [15:0] ram_addr
);
    logic [15:0] base;

    // Codes above the last window never map; 110 and 111 are treated as 101.
    assign base     = FLASH_WIN_BASE + 16'(window) * WIN_SIZE;
    assign hit      = map_on && (window <= WIN_LAST) && ((cpu_addr & WIN_MASK) == base);
    assign ram_addr = RAM_WIN_BASE | (cpu_addr & ~WIN_MASK);

endmodule : froe_overlay_map

// ---- froe_pkg.sv ----
package froe_pkg;

    // ------------------------------------------------------------------
    // Register map (byte addresses)
    // ------------------------------------------------------------------
    localparam logic [7:0] ADDR_RAMCTL   = 8'h00;
    localparam logic [7:0] ADDR_FMODE    = 8'h04;
    localparam logic [7:0] ADDR_EVSTAT   = 8'h08;

    // ------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------
    localparam int BIT_RAM_EN  = 7;
    localparam int BIT_TEST    = 6;
    localparam int BIT_ONE     = 5;
    localparam int BIT_ERR     = 4;
    localparam int BIT_OVL_SEL = 3;
    localparam int BIT_WIN_HI  = 2;
    localparam int BIT_VPP     = 7;
    localparam int BIT_EV      = 3;
    localparam int BIT_PV      = 2;
    localparam int BIT_ERASE   = 1;
    localparam int BIT_PROG    = 0;

    localparam logic [7:0] RAMCTL_RST    = 8'hb0;
    localparam logic [7:0] FMODE_RST     = 8'h00;
    localparam logic [2:0] WIN_NOMAP     = 3'h5;
    localparam logic [2:0] WIN_LAST      = 3'h4;
    localparam logic [15:0] FLASH_WIN_BASE = 16'hec00;
    localparam logic [15:0] RAM_WIN_BASE   = 16'hf680;
    localparam logic [15:0] WIN_SIZE       = 16'h0080;
    localparam logic [15:0] WIN_MASK       = 16'hff80;

    // ------------------------------------------------------------------
    // Types
    // ------------------------------------------------------------------
    typedef struct packed {
        logic        valid;
        logic [15:0] addr;
        logic        fetch;
    } froe_rd_t;

    typedef struct packed {
        logic        hw_exception;
        logic        sleep_exec;
    } froe_cpu_ev_t;

    typedef enum logic [1:0] {
        FM_IDLE,
        FM_ACTIVE
    } froe_fm_state_t;

endpackage : froe_pkg

// ---- tb_flash_ram_overlay_error_protect.sv ----
`timescale 1ns/1ns
module tb_flash_ram_overlay_error_protect;
    import froe_pkg::*;

    // ------------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [2:0]  win;
        logic [15:0] addr;
        logic        hit;
        logic [15:0] ram;
    } froe_row_t;

    logic                  clock = 1'b0;
    logic                  rst_n = 1'b0;
    logic                  psel = 1'b0;
    logic                  penable = 1'b0;
    logic                  pwrite = 1'b0;
    logic [7:0]            paddr = 8'h00;
    logic [31:0]           pwdata = 32'h0;
    logic [31:0]           prdata;
    logic                  pready;
    logic                  pslverr;
    logic                  vpp = 1'b1;
    logic                  onboard = 1'b1;
    logic                  hw_standby = 1'b0;
    froe_rd_t              flash_rd;
    froe_cpu_ev_t          cpu_ev;
    logic                  pg, er, pv, ev, ram_en, hit, undef_rd;
    logic [15:0]           ram_addr;
    wire logic [3:0]       modes = {ev, pv, er, pg};
    logic [31:0]           rd;
    logic                  err;
    int                    n_errors = 0;
    int                    num_checks = 0;
    int                    i;
    froe_row_t             rows [11];

    always #5 clock = ~clock;

    froe_cpu_model cpu (.clk(clock), .flash_rd(flash_rd), .cpu_ev(cpu_ev));

    froe_flash_ctrl dut (
        .CLOCK(clock), .RST_N(rst_n), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
        .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
        .PSLVERR(pslverr), .VPP_12V_PRESENT(vpp), .ONBOARD_MODE(onboard),
        .HW_STANDBY(hw_standby), .FLASH_RD(flash_rd), .CPU_EV(cpu_ev),
        .PROG_ACTIVE(pg), .ERASE_ACTIVE(er), .PV_ACTIVE(pv), .EV_ACTIVE(ev),
        .RAM_ACCESS_ENABLE(ram_en), .OVERLAY_HIT(hit), .OVERLAY_RAM_ADDR(ram_addr),
        .RD_DATA_UNDEFINED(undef_rd)
    );

    // ------------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------------
    task automatic close_out;
        if (n_errors == 0 && num_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : close_out

    task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            n_errors++;
            $display("mismatch at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask : chk_reg

    task automatic chk_sig(input logic [15:0] got, input logic [15:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            n_errors++;
            $display("mismatch at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask : chk_sig

    task automatic tick(input int n);
        repeat (n) @(posedge clock);
    endtask : tick

    // The idle edge first keeps psel from being lowered and raised in one step.
    task automatic apb(input logic wr, input logic [7:0] a, input logic [7:0] d);
        int k;
        @(posedge clock);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= {24'h0, d};
        @(posedge clock);
        penable <= 1'b1;
        for (k = 0; k < 16; k++)
        begin
            @(posedge clock);
            if (pready === 1'b1)
                break;
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (k == 16)
        begin
            n_errors++;
            close_out();
        end
    endtask : apb

    task automatic wreg(input logic [7:0] a, input logic [7:0] d);
        apb(1'b1, a, d);
    endtask : wreg

    // Bit six is a test bit with no defined read value, so it is masked.
    task automatic rreg(input logic [7:0] a, input logic [7:0] exp);
        apb(1'b0, a, 8'h00);
        chk_reg(rd & 32'hffff_ffbf, {24'h0, exp});
        chk_sig({15'h0, err}, 16'h0);
    endtask : rreg

    task automatic wait_mode(input logic [3:0] exp);
        int k;
        for (k = 0; k < 10 && modes !== exp; k++)
            tick(1);
        chk_sig({12'h0, modes}, {12'h0, exp});
        if (modes !== exp)
            close_out();
    endtask : wait_mode

    task automatic do_reset;
        rst_n <= 1'b0;
        tick(16);
        rst_n <= 1'b1;
        tick(1);
    endtask : do_reset

    // ------------------------------------------------------------------
    // Sequence
    // ------------------------------------------------------------------
    initial
    begin
        rows = '{'{3'h0, 16'hec00, 1'b1, 16'hf680}, '{3'h0, 16'hec7f, 1'b1, 16'hf6ff},
                 '{3'h1, 16'hec80, 1'b1, 16'hf680}, '{3'h2, 16'hed05, 1'b1, 16'hf685},
                 '{3'h3, 16'hedff, 1'b1, 16'hf6ff}, '{3'h4, 16'hee00, 1'b1, 16'hf680},
                 '{3'h4, 16'hee80, 1'b0, 16'h0},    '{3'h5, 16'hec00, 1'b0, 16'h0},
                 '{3'h6, 16'hec00, 1'b0, 16'h0},    '{3'h7, 16'hee00, 1'b0, 16'h0},
                 '{3'h1, 16'hec7f, 1'b0, 16'h0}};
        do_reset();
        chk_sig({15'h0, ram_en}, 16'h1);
        chk_sig({12'h0, modes}, 16'h0);
        rreg(ADDR_RAMCTL, 8'ha0);
        rreg(ADDR_FMODE, 8'h80);
        apb(1'b0, ADDR_EVSTAT, 8'h00);
        chk_reg(rd, 32'h0);
        chk_sig({15'h0, err}, 16'h1);
        cpu.pulse_event(1'b1, 1'b1);
        rreg(ADDR_RAMCTL, 8'ha0);
        wreg(ADDR_RAMCTL, 8'h90);
        rreg(ADDR_RAMCTL, 8'ha0);
        for (i = 0; i < 11; i++)
        begin
            wreg(ADDR_RAMCTL, {5'h11, rows[i].win});
            rreg(ADDR_RAMCTL, {5'h15, rows[i].win});
            cpu.read_flash(rows[i].addr, 1'b0);
            tick(1);
            chk_sig({15'h0, hit}, {15'h0, rows[i].hit});
            if (rows[i].hit)
                chk_sig(ram_addr, rows[i].ram);
        end
        wreg(ADDR_FMODE, 8'h01);
        tick(4);
        chk_sig({12'h0, modes}, 16'h0);
        wreg(ADDR_FMODE, 8'h02);
        tick(4);
        chk_sig({12'h0, modes}, 16'h0);
        wreg(ADDR_FMODE, 8'h04);
        wait_mode(4'h4);
        wreg(ADDR_FMODE, 8'h00);
        wreg(ADDR_RAMCTL, 8'h08);
        tick(2);
        chk_sig({15'h0, ram_en}, 16'h0);
        cpu.read_flash(16'hec00, 1'b0);
        tick(1);
        chk_sig({15'h0, hit}, 16'h0);
        onboard <= 1'b0;
        rreg(ADDR_RAMCTL, 8'h20);
        wreg(ADDR_RAMCTL, 8'h8c);
        rreg(ADDR_RAMCTL, 8'ha0);
        onboard <= 1'b1;
        vpp <= 1'b0;
        wreg(ADDR_RAMCTL, 8'h89);
        rreg(ADDR_RAMCTL, 8'ha0);
        rreg(ADDR_FMODE, 8'h00);
        vpp <= 1'b1;
        wreg(ADDR_RAMCTL, 8'h89);
        rreg(ADDR_RAMCTL, 8'ha9);
        vpp <= 1'b0;
        rreg(ADDR_RAMCTL, 8'ha0);
        vpp <= 1'b1;
        wreg(ADDR_RAMCTL, 8'h80);
        for (i = 0; i < 4; i++)
        begin
            wreg(ADDR_FMODE, 8'(1 << i));
            wait_mode(4'(1 << i));
            wreg(ADDR_FMODE, 8'h00);
            wait_mode(4'h0);
        end
        wreg(ADDR_FMODE, 8'h01);
        wait_mode(4'h1);
        cpu.read_flash(16'h1000, 1'b1);
        tick(1);
        chk_sig({15'h0, undef_rd}, 16'h1);
        wait_mode(4'h0);
        rreg(ADDR_RAMCTL, 8'hb0);
        wreg(ADDR_FMODE, 8'h00);
        wreg(ADDR_FMODE, 8'h02);
        tick(4);
        chk_sig({12'h0, modes}, 16'h0);
        wreg(ADDR_RAMCTL, 8'h80);
        rreg(ADDR_RAMCTL, 8'hb0);
        wreg(ADDR_FMODE, 8'h00);
        hw_standby <= 1'b1;
        tick(2);
        hw_standby <= 1'b0;
        rreg(ADDR_RAMCTL, 8'ha0);
        wreg(ADDR_RAMCTL, 8'h80);
        wreg(ADDR_FMODE, 8'h01);
        wait_mode(4'h1);
        cpu.pulse_event(1'b0, 1'b1);
        wait_mode(4'h0);
        rreg(ADDR_RAMCTL, 8'hb0);
        do_reset();
        rreg(ADDR_RAMCTL, 8'ha0);
        wreg(ADDR_FMODE, 8'h01);
        cpu.pulse_event(1'b1, 1'b0);
        rreg(ADDR_RAMCTL, 8'hb0);
        close_out();
    end

endmodule : tb_flash_ram_overlay_error_protect
